/* File: src/err_evt_pkg.sv */
package err_evt_pkg;
    localparam int          addr_w              = 5;
    // byte addresses over the bus
    localparam logic [4:0]  off_et_far          = 5'h00;
    localparam logic [4:0]  off_nt_near         = 5'h04;
    localparam logic [4:0]  off_nt_far_lo       = 5'h08;
    localparam logic [4:0]  off_nt_far_hi       = 5'h0c;
    localparam logic [4:0]  off_auto_ctrl       = 5'h10;
    localparam logic [4:0]  off_test_pattern    = 5'h14;
    localparam logic [4:0]  off_irq_status      = 5'h18;
    localparam logic [4:0]  off_irq_mask        = 5'h1c;
    localparam logic [7:0]  rst_val             = 8'h00;
    // writable bit masks
    localparam logic [7:0]  mask_et_far         = 8'hff;
    localparam logic [7:0]  mask_nt_near        = 8'haf;
    localparam logic [7:0]  mask_nt_far_lo      = 8'h1f;
    localparam logic [7:0]  mask_nt_far_hi      = 8'h0f;
    localparam logic [7:0]  mask_auto_ctrl      = 8'hdb;
    // auto control fields
    localparam int          b_auto_sys_alarm_on_frame_loss = 0;
    localparam int          b_auto_sys_alarm_on_crc_timeout = 1;
    localparam int          b_force_sys_alarm   = 3;
    localparam int          b_auto_line_loop_en = 4;
    localparam int          b_auto_dl_line_loop_en = 6;
    localparam int          b_auto_dl_payload_loop_en = 7;
    // test pattern fields
    localparam int          b_send_loop_activate_code = 4;
    localparam int          b_send_loop_release_code = 5;
    localparam logic [4:0]  loop_on_pattern     = 5'h01;
    localparam logic [2:0]  loop_off_pattern    = 3'h1;
    localparam int          loop_on_len         = 5;
    localparam int          loop_off_len        = 3;
    // interrupt status bits
    localparam int          irq_w               = 4;
    localparam int          b_irq_es            = 0;
    localparam int          b_irq_sys_alarm     = 1;
    localparam int          b_irq_line_loop     = 2;
    localparam int          b_irq_payload_loop  = 3;
    localparam logic [1:0]  htrans_nonseq       = 2'b10;
    localparam logic [2:0]  hsize_word          = 3'b010;
endpackage

/* File: src/event_qualifier.sv */
`timescale 1ns/1ps
module event_qualifier #(
    parameter int n = 8
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic [n-1:0] events,
    input  wire logic [n-1:0] enables,
    output logic              hit_r
);
    wire any_hit = |(events & enables);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hit_r <= 1'b0;
        end else if (ce) begin
            hit_r <= any_hit;
        end
    end
endmodule

/* File: src/loop_code_gen.sv */
`timescale 1ns/1ps
module loop_code_gen
    import err_evt_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic bit_tick,
    input  wire logic send_on,
    input  wire logic send_off,
    output logic      code_valid_r,
    output logic      code_bit_r
);
    logic [2:0] pos_r;
    wire  [2:0] last_pos = send_on ? 3'(loop_on_len - 1) : 3'(loop_off_len - 1);
    wire        wrap     = (pos_r >= last_pos);
    wire  [2:0] pos_nxt  = wrap ? 3'h0 : pos_r + 3'h1;
    wire        cur_bit  = send_on ? loop_on_pattern[3'(loop_on_len - 1) - pos_r]
                                   : loop_off_pattern[2'(3'(loop_off_len - 1) - pos_r)];
    wire        active   = send_on ^ send_off;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pos_r        <= 3'h0;
            code_valid_r <= 1'b0;
            code_bit_r   <= 1'b0;
        end else if (ce) begin
            if (!active) begin
                pos_r        <= 3'h0;
                code_valid_r <= 1'b0;
                code_bit_r   <= 1'b0;
            end else if (bit_tick) begin
                pos_r        <= pos_nxt;
                code_valid_r <= 1'b1;
                code_bit_r   <= cur_bit;
            end
        end
    end
endmodule

/* File: src/errored_event_and_auto_ais_ctrl.sv */
`timescale 1ns/1ps
// How it works
// - set enable bit lets far event count
// - et far bits: sa6f sa6e sa68 rfa slip ais mf fa
// - one enabled event bumps es and ses
// - nt near bits 7,5,3..0; bits 6,4 zero
// - nt far lo bits 4..0, hi bits 3..0
// - auto alarm while frame alignment lost
// - alarm after crc timer, while mf lost
// - forced alarm toward system always
// - act on in-band line loop codes
// - act on data-link line loop commands
// - act on data-link payload loop commands
// - test pattern register, resets to zero
// - bit4 alone sends 00001, bit5 alone sends 001
module errored_event_and_auto_ais_ctrl
    import err_evt_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 nrst,
    input  wire logic                 ce,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic [31:0]               hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire logic [7:0]           et_far_events,
    input  wire logic [7:0]           nt_near_events,
    input  wire logic [4:0]           nt_far_events_lo,
    input  wire logic [3:0]           nt_far_events_hi,
    input  wire logic                 rx_frame_loss_state,
    input  wire logic                 crc_timer_expired,
    input  wire logic                 crc_mf_loss_state,
    input  wire logic                 inband_loop_on_det,
    input  wire logic                 inband_loop_off_det,
    input  wire logic                 dl_line_loop_on_cmd,
    input  wire logic                 dl_line_loop_off_cmd,
    input  wire logic                 dl_payload_loop_on_cmd,
    input  wire logic                 dl_payload_loop_off_cmd,
    input  wire logic                 tx_bit_tick,
    output logic                      es_inc_r,
    output logic                      ses_inc_r,
    output logic                      sys_alarm_r,
    output logic                      line_loop_r,
    output logic                      payload_loop_r,
    output logic [7:0]                test_pattern_r,
    output logic                      loop_code_valid_r,
    output logic                      loop_code_bit_r,
    output logic                      irq_r
);
    logic        rs1_r;
    logic        rst_n;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rs1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rst_n <= rs1_r;
        end
    end

    logic [7:0]       et_far_r, nt_near_r, nt_far_lo_r, nt_far_hi_r, auto_ctrl_r;
    logic [irq_w-1:0] irq_status_r, irq_mask_r;
    logic             wr_pend_r;
    logic [4:0]       wr_addr_r;
    logic             crc_alarm_r;

    // bus decode
    wire        take    = hsel & hready & htrans[1];
    wire        rd_take = take & ~hwrite;
    wire        wr_take = take & hwrite;
    wire  [4:0] a_addr  = {haddr[4:2], 2'b00};
    wire  [7:0] wd      = hwdata[7:0];
    function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
        hit = (a == off);
    endfunction
    wire        rd_status = rd_take & hit(a_addr, off_irq_status);
    wire [7:0]  rd_mux =
        hit(a_addr, off_et_far)       ? et_far_r :
        hit(a_addr, off_nt_near)      ? nt_near_r :
        hit(a_addr, off_nt_far_lo)    ? nt_far_lo_r :
        hit(a_addr, off_nt_far_hi)    ? nt_far_hi_r :
        hit(a_addr, off_auto_ctrl)    ? auto_ctrl_r :
        hit(a_addr, off_test_pattern) ? test_pattern_r :
        hit(a_addr, off_irq_status)   ? {4'h0, irq_status_r} :
        hit(a_addr, off_irq_mask)     ? {4'h0, irq_mask_r} : 8'h00;
    wire in_map = (haddr[31:5] == 27'h0);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 5'h00;
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (ce) begin
            wr_pend_r <= wr_take & in_map;
            wr_addr_r <= a_addr;
            if (rd_take) begin
                hrdata <= in_map ? {24'h0, rd_mux} : 32'h0;
            end
        end
    end

    wire wr_now = wr_pend_r;
    function automatic logic [7:0] wmask(input logic [7:0] v, input logic [7:0] m);
        wmask = v & m;
    endfunction

    // enable, test pattern and interrupt mask registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            et_far_r       <= rst_val;
            nt_near_r      <= rst_val;
            nt_far_lo_r    <= rst_val;
            nt_far_hi_r    <= rst_val;
            auto_ctrl_r    <= rst_val;
            test_pattern_r <= rst_val;
            irq_mask_r     <= '0;
        end else if (ce && wr_now) begin
            if (hit(wr_addr_r, off_et_far))       et_far_r       <= wmask(wd, mask_et_far);
            if (hit(wr_addr_r, off_nt_near))      nt_near_r      <= wmask(wd, mask_nt_near);
            if (hit(wr_addr_r, off_nt_far_lo))    nt_far_lo_r    <= wmask(wd, mask_nt_far_lo);
            if (hit(wr_addr_r, off_nt_far_hi))    nt_far_hi_r    <= wmask(wd, mask_nt_far_hi);
            if (hit(wr_addr_r, off_auto_ctrl))    auto_ctrl_r    <= wmask(wd, mask_auto_ctrl);
            if (hit(wr_addr_r, off_test_pattern)) test_pattern_r <= wd;
            if (hit(wr_addr_r, off_irq_mask))     irq_mask_r     <= wd[irq_w-1:0];
        end
    end

    // event qualification
    logic et_hit, nn_hit, nf_hit;
    event_qualifier #(.n(8)) u_q_et (
        .mclk(mclk), .rst_n(rst_n), .ce(ce),
        .events(et_far_events), .enables(et_far_r), .hit_r(et_hit)
    );
    event_qualifier #(.n(8)) u_q_nn (
        .mclk(mclk), .rst_n(rst_n), .ce(ce),
        .events(nt_near_events & mask_nt_near), .enables(nt_near_r), .hit_r(nn_hit)
    );
    event_qualifier #(.n(9)) u_q_nf (
        .mclk(mclk), .rst_n(rst_n), .ce(ce),
        .events({nt_far_events_hi, nt_far_events_lo}),
        .enables({nt_far_hi_r[3:0], nt_far_lo_r[4:0]}), .hit_r(nf_hit)
    );
    wire any_err = et_hit | nn_hit | nf_hit;

    // alarm and loopback control
    wire frame_alarm = auto_ctrl_r[b_auto_sys_alarm_on_frame_loss] & rx_frame_loss_state;
    wire crc_en      = auto_ctrl_r[b_auto_sys_alarm_on_crc_timeout];
    wire crc_nxt     = crc_en & crc_mf_loss_state & (crc_alarm_r | crc_timer_expired);
    wire alarm_nxt   = auto_ctrl_r[b_force_sys_alarm] | frame_alarm | crc_nxt;
    wire ll_on  = (auto_ctrl_r[b_auto_line_loop_en] & inband_loop_on_det) |
                  (auto_ctrl_r[b_auto_dl_line_loop_en] & dl_line_loop_on_cmd);
    wire ll_off = (auto_ctrl_r[b_auto_line_loop_en] & inband_loop_off_det) |
                  (auto_ctrl_r[b_auto_dl_line_loop_en] & dl_line_loop_off_cmd);
    wire pl_on  = auto_ctrl_r[b_auto_dl_payload_loop_en] & dl_payload_loop_on_cmd;
    wire pl_off = auto_ctrl_r[b_auto_dl_payload_loop_en] & dl_payload_loop_off_cmd;
    wire ll_nxt = ll_on ? 1'b1 : (ll_off ? 1'b0 : line_loop_r);
    wire pl_nxt = pl_on ? 1'b1 : (pl_off ? 1'b0 : payload_loop_r);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            es_inc_r       <= 1'b0;
            ses_inc_r      <= 1'b0;
            crc_alarm_r    <= 1'b0;
            sys_alarm_r    <= 1'b0;
            line_loop_r    <= 1'b0;
            payload_loop_r <= 1'b0;
        end else if (ce) begin
            es_inc_r       <= any_err;
            ses_inc_r      <= any_err;
            crc_alarm_r    <= crc_nxt;
            sys_alarm_r    <= alarm_nxt;
            line_loop_r    <= ll_nxt;
            payload_loop_r <= pl_nxt;
        end
    end

    // interrupts: set wins over read clear
    wire [irq_w-1:0] irq_set = {pl_nxt ^ payload_loop_r, ll_nxt ^ line_loop_r,
                                alarm_nxt & ~sys_alarm_r, any_err};
    wire [irq_w-1:0] irq_nxt = (rd_status ? '0 : irq_status_r) | irq_set;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status_r <= '0;
            irq_r        <= 1'b0;
        end else if (ce) begin
            irq_status_r <= irq_nxt;
            irq_r        <= |(irq_nxt & irq_mask_r);
        end
    end

    // loop code sender, host must pass through zero
    loop_code_gen u_gen (
        .mclk(mclk), .rst_n(rst_n), .ce(ce), .bit_tick(tx_bit_tick),
        .send_on(test_pattern_r[b_send_loop_activate_code]),
        .send_off(test_pattern_r[b_send_loop_release_code]),
        .code_valid_r(loop_code_valid_r), .code_bit_r(loop_code_bit_r)
    );

    property p_es_ses;
        @(posedge mclk) disable iff (!rst_n)
        ce & $past(ce) & $past(ce, 2) & $past(et_far_events[0] & et_far_r[0], 2) |-> es_inc_r & ses_inc_r;
    endproperty
    a_es_ses: assert property (p_es_ses) else $error("enabled event not counted");
    property p_es_off;
        @(posedge mclk) disable iff (!rst_n)
        ce & $past(ce) & $past(ce, 2) & $past(et_far_r == 8'h00 & nt_near_r == 8'h00 & nt_far_lo_r == 8'h00
            & nt_far_hi_r == 8'h00, 2) |-> !es_inc_r;
    endproperty
    a_es_off: assert property (p_es_off) else $error("disabled event counted");
    property p_force;
        @(posedge mclk) disable iff (!rst_n)
        ce & auto_ctrl_r[b_force_sys_alarm] |=> !ce | sys_alarm_r;
    endproperty
    a_force: assert property (p_force) else $error("forced alarm missing");
    property p_frame;
        @(posedge mclk) disable iff (!rst_n)
        ce & auto_ctrl_r[b_auto_sys_alarm_on_frame_loss] & rx_frame_loss_state |=> !ce | sys_alarm_r;
    endproperty
    a_frame: assert property (p_frame) else $error("frame loss alarm missing");
    property p_crc;
        @(posedge mclk) disable iff (!rst_n)
        ce & crc_alarm_r & !crc_mf_loss_state |=> !ce | !crc_alarm_r;
    endproperty
    a_crc: assert property (p_crc) else $error("crc alarm outlived mf loss");
    property p_reserved;
        @(posedge mclk) disable iff (!rst_n)
        nt_near_r[6] == 1'b0 && nt_near_r[4] == 1'b0 && nt_far_lo_r[7:5] == 3'h0 && nt_far_hi_r[7:4] == 4'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");
    property p_ll;
        @(posedge mclk) disable iff (!rst_n)
        ce & !auto_ctrl_r[b_auto_line_loop_en] & !auto_ctrl_r[b_auto_dl_line_loop_en] |=> !ce | $stable(line_loop_r);
    endproperty
    a_ll: assert property (p_ll) else $error("line loop moved while disabled");
    property p_pl;
        @(posedge mclk) disable iff (!rst_n)
        ce & pl_on |=> !ce | payload_loop_r;
    endproperty
    a_pl: assert property (p_pl) else $error("payload loop not entered");
    property p_nn_hit;
        @(posedge mclk) disable iff (!rst_n)
        ce & $past(ce) & $past(ce, 2) & $past(nt_near_events[7] & nt_near_r[7], 2) |-> es_inc_r & ses_inc_r;
    endproperty
    a_nn_hit: assert property (p_nn_hit) else $error("near event not counted");
    property p_nf_lo_hit;
        @(posedge mclk) disable iff (!rst_n)
        ce & $past(ce) & $past(ce, 2) & $past(nt_far_events_lo[4] & nt_far_lo_r[4], 2) |-> es_inc_r & ses_inc_r;
    endproperty
    a_nf_lo_hit: assert property (p_nf_lo_hit) else $error("far low event not counted");
    property p_nf_hi_hit;
        @(posedge mclk) disable iff (!rst_n)
        ce & $past(ce) & $past(ce, 2) & $past(nt_far_events_hi[0] & nt_far_hi_r[0], 2) |-> es_inc_r & ses_inc_r;
    endproperty
    a_nf_hi_hit: assert property (p_nf_hi_hit) else $error("far high event not counted");
    property p_quiet;
        @(posedge mclk) disable iff (!rst_n)
        ce & $past(ce) & $past(ce, 2) & $past((nt_near_events & ~mask_nt_near) == nt_near_events
            & et_far_events == 8'h00 & nt_far_events_lo == 5'h00 & nt_far_events_hi == 4'h00, 2) |-> !es_inc_r;
    endproperty
    a_quiet: assert property (p_quiet) else $error("count without valid event");
    property p_crc_set;
        @(posedge mclk) disable iff (!rst_n)
        ce & auto_ctrl_r[b_auto_sys_alarm_on_crc_timeout] & crc_mf_loss_state & crc_timer_expired
            |=> !ce | sys_alarm_r;
    endproperty
    a_crc_set: assert property (p_crc_set) else $error("crc timeout alarm missing");
    property p_no_cause;
        @(posedge mclk) disable iff (!rst_n)
        ce & !auto_ctrl_r[b_force_sys_alarm] & !(auto_ctrl_r[b_auto_sys_alarm_on_frame_loss] & rx_frame_loss_state)
            & !(auto_ctrl_r[b_auto_sys_alarm_on_crc_timeout] & crc_mf_loss_state) |=> !ce | !sys_alarm_r;
    endproperty
    a_no_cause: assert property (p_no_cause) else $error("alarm without cause");
    property p_ll_on;
        @(posedge mclk) disable iff (!rst_n)
        ce & auto_ctrl_r[b_auto_line_loop_en] & inband_loop_on_det |=> !ce | line_loop_r;
    endproperty
    a_ll_on: assert property (p_ll_on) else $error("in-band line loop not entered");
    property p_ll_off;
        @(posedge mclk) disable iff (!rst_n)
        ce & auto_ctrl_r[b_auto_line_loop_en] & inband_loop_off_det & !inband_loop_on_det & !dl_line_loop_on_cmd
            |=> !ce | !line_loop_r;
    endproperty
    a_ll_off: assert property (p_ll_off) else $error("in-band line loop not left");
    property p_dl_ll_on;
        @(posedge mclk) disable iff (!rst_n)
        ce & auto_ctrl_r[b_auto_dl_line_loop_en] & dl_line_loop_on_cmd |=> !ce | line_loop_r;
    endproperty
    a_dl_ll_on: assert property (p_dl_ll_on) else $error("data-link line loop not entered");
    property p_pl_off;
        @(posedge mclk) disable iff (!rst_n)
        ce & auto_ctrl_r[b_auto_dl_payload_loop_en] & dl_payload_loop_off_cmd & !dl_payload_loop_on_cmd
            |=> !ce | !payload_loop_r;
    endproperty
    a_pl_off: assert property (p_pl_off) else $error("payload loop not left");
    property p_code_idle;
        @(posedge mclk) disable iff (!rst_n)
        ce & !test_pattern_r[b_send_loop_activate_code] & !test_pattern_r[b_send_loop_release_code]
            |=> !ce | !loop_code_valid_r;
    endproperty
    a_code_idle: assert property (p_code_idle) else $error("code sent while idle");
endmodule

/* File: dv/host_bus_model.sv */
`timescale 1ns/1ps
module host_bus_model (
    input  wire logic        mclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    import err_evt_pkg::*;
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize  = hsize_word;
        hwdata = 32'h0;
    end
    // one single word transfer, held until hready
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge mclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= htrans_nonseq;
        hwrite <= w;
        do @(posedge mclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge mclk); while (hready !== 1'b1);
        r = hrdata;
    endtask
endmodule

/* File: dv/errored_event_and_auto_ais_ctrl_test.sv */
`timescale 1ns/1ps
module errored_event_and_auto_ais_ctrl_test;
    import err_evt_pkg::*;
    logic mclk, nrst, ce, hsel, hwrite, hready, hresp, tick;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  etf, ntn, tp;
    logic [4:0]  nfl;
    logic [3:0]  nfh;
    logic rfl, crt, cml, ion, iof, dlon, dloff, dpon, dpoff;
    logic es, ses, alarm, lloop, ploop, cval, cbit, irq;
    int fail_count, n_compared, cyc;
    host_bus_model host_bus_model_inst (.mclk(mclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    errored_event_and_auto_ais_ctrl errored_event_and_auto_ais_ctrl_inst (.mclk(mclk), .nrst(nrst),
        .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
        .et_far_events(etf), .nt_near_events(ntn), .nt_far_events_lo(nfl), .nt_far_events_hi(nfh),
        .rx_frame_loss_state(rfl), .crc_timer_expired(crt), .crc_mf_loss_state(cml),
        .inband_loop_on_det(ion), .inband_loop_off_det(iof), .dl_line_loop_on_cmd(dlon),
        .dl_line_loop_off_cmd(dloff), .dl_payload_loop_on_cmd(dpon), .dl_payload_loop_off_cmd(dpoff),
        .tx_bit_tick(tick), .es_inc_r(es), .ses_inc_r(ses), .sys_alarm_r(alarm), .line_loop_r(lloop),
        .payload_loop_r(ploop), .test_pattern_r(tp), .loop_code_valid_r(cval),
        .loop_code_bit_r(cbit), .irq_r(irq));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            fail_count++;
            print_verdict;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] r;
        host_bus_model_inst.xfer(1'b1, a, {24'h0, d}, r);
    endtask
    task automatic rdc(input logic [31:0] a, input logic [7:0] e);
        logic [31:0] r;
        host_bus_model_inst.xfer(1'b0, a, 32'h0, r);
        chk(r, {24'h0, e});
    endtask
    task automatic t_regs;
        logic [4:0] offs [5] = '{off_et_far, off_nt_near, off_nt_far_lo, off_nt_far_hi, off_auto_ctrl};
        logic [7:0] msk [5] = '{8'hff, 8'haf, 8'h1f, 8'h0f, 8'hdb};
        for (int i = 0; i < 5; i++) rdc({27'h0, offs[i]}, 8'h00);
        rdc({27'h0, off_test_pattern}, 8'h00);
        for (int i = 0; i < 5; i++) begin
            wr({27'h0, offs[i]}, 8'hff);
            rdc({27'h0, offs[i]}, msk[i]);
            wr({27'h0, offs[i]}, 8'h00);
        end
        wr(32'h40, 8'hff);
        rdc(32'h40, 8'h00);
        chk({hresp, hready}, 2'b01);
    endtask
    task automatic ev(input logic [4:0] off, input logic [7:0] en, input int g, input logic [7:0] e, input logic x);
        logic se, ss;
        se = 1'b0;
        ss = 1'b0;
        wr({27'h0, off}, en);
        case (g)
            0: etf <= e;
            1: ntn <= e;
            2: nfl <= e[4:0];
            default: nfh <= e[3:0];
        endcase
        @(posedge mclk);
        {etf, ntn, nfl, nfh} <= '0;
        repeat (6) begin
            @(posedge mclk);
            se |= es;
            ss |= ses;
        end
        chk({se, ss}, {x, x});
        wr({27'h0, off}, 8'h00);
    endtask
    task automatic t_alarm;
        rfl <= 1'b1;
        step(3);
        chk(alarm, 1'b0);
        wr(off_auto_ctrl, 8'h01);
        step(3);
        chk(alarm, 1'b1);
        rfl <= 1'b0;
        wr(off_auto_ctrl, 8'h02);
        cml <= 1'b1;
        step(3);
        chk(alarm, 1'b0);
        crt <= 1'b1;
        step(1);
        crt <= 1'b0;
        step(5);
        chk(alarm, 1'b1);
        cml <= 1'b0;
        step(3);
        chk(alarm, 1'b0);
        wr(off_auto_ctrl, 8'h08);
        step(3);
        chk(alarm, 1'b1);
        wr(off_auto_ctrl, 8'h00);
    endtask
    task automatic lp(input logic [7:0] en, input int k, input logic x);
        wr(off_auto_ctrl, en);
        {ion, dlon, dpon} <= 3'b100 >> k;
        step(1);
        {ion, dlon, dpon} <= 3'b000;
        step(3);
        chk({lloop, ploop}, (k == 2) ? {1'b0, x} : {x, 1'b0});
        {iof, dloff, dpoff} <= 3'b100 >> k;
        step(1);
        {iof, dloff, dpoff} <= 3'b000;
        step(3);
        chk({lloop, ploop}, 2'b00);
        wr(off_auto_ctrl, 8'h00);
    endtask
    task automatic code(input int p);
        logic [14:0] b;
        int ones, bad, n;
        ones = 0;
        bad = 0;
        n = 0;
        while (n < 15 && cyc < 7900) begin
            @(posedge mclk);
            if (cval === 1'b1) begin
                b[n] = cbit;
                n++;
            end
        end
        for (int i = 0; i < 15; i++) ones += (b[i] === 1'b1);
        for (int i = 0; i + p < 15; i++) bad += (b[i] !== b[i+p]);
        chk({ones[15:0], bad[15:0]}, {16'(15 / p), 16'h0});
    endtask
    task automatic t_code;
        tick <= 1'b1;
        wr(off_test_pattern, 8'h10);
        rdc({27'h0, off_test_pattern}, 8'h10);
        chk(tp, 8'h10);
        code(loop_on_len);
        wr(off_test_pattern, 8'h00);
        step(4);
        chk(cval, 1'b0);
        wr(off_test_pattern, 8'h20);
        code(loop_off_len);
        wr(off_test_pattern, 8'h00);
    endtask
    task automatic t_irq;
        logic [31:0] r;
        host_bus_model_inst.xfer(1'b0, {27'h0, off_irq_status}, 32'h0, r);
        wr(off_irq_mask, 8'h02);
        rdc({27'h0, off_irq_mask}, 8'h02);
        wr(off_auto_ctrl, 8'h08);
        step(3);
        chk(irq, 1'b1);
        rdc({27'h0, off_irq_status}, 8'h02);
        step(2);
        chk(irq, 1'b0);
        wr(off_auto_ctrl, 8'h00);
        wr(off_irq_mask, 8'h00);
        wr(off_auto_ctrl, 8'h08);
        step(3);
        chk(irq, 1'b0);
        rdc({27'h0, off_irq_status}, 8'h02);
        wr(off_auto_ctrl, 8'h00);
    endtask
    task automatic t_freeze;
        wr(off_auto_ctrl, 8'h08);
        step(2);
        ce <= 1'b0;
        wr(off_auto_ctrl, 8'h00);
        step(3);
        chk(alarm, 1'b1);
        ce <= 1'b1;
        rdc({27'h0, off_auto_ctrl}, 8'h08);
        wr(off_auto_ctrl, 8'h00);
        step(3);
        chk(alarm, 1'b0);
    endtask
    task automatic t_reset;
        wr({27'h0, off_et_far}, 8'hff);
        wr(off_test_pattern, 8'h10);
        wr(off_auto_ctrl, 8'h08);
        step(2);
        nrst <= 1'b0;
        step(2);
        chk({alarm, tp}, 9'h000);
        nrst <= 1'b1;
        step(4);
        rdc({27'h0, off_et_far}, 8'h00);
        rdc({27'h0, off_auto_ctrl}, 8'h00);
        chk({alarm, cval}, 2'b00);
    endtask
    initial begin
        fail_count = 0;
        n_compared = 0;
        cyc = 0;
        nrst = 1'b0;
        tick = 1'b0;
        ce = 1'b1;
        {etf, ntn, nfl, nfh} = '0;
        {rfl, crt, cml, ion, iof, dlon, dloff, dpon, dpoff} = '0;
        step(20);
        nrst <= 1'b1;
        step(4);
        t_regs;
        ev(off_et_far, 8'h08, 0, 8'h08, 1'b1);
        ev(off_et_far, 8'hf7, 0, 8'h08, 1'b0);
        ev(off_nt_near, 8'hff, 1, 8'h50, 1'b0);
        ev(off_nt_near, 8'h80, 1, 8'h80, 1'b1);
        ev(off_nt_far_lo, 8'h10, 2, 8'h10, 1'b1);
        ev(off_nt_far_hi, 8'h01, 3, 8'h01, 1'b1);
        t_alarm;
        lp(8'h10, 0, 1'b1);
        lp(8'h00, 0, 1'b0);
        lp(8'h40, 1, 1'b1);
        lp(8'h80, 2, 1'b1);
        lp(8'h10, 2, 1'b0);
        t_code;
        t_irq;
        t_freeze;
        t_reset;
        print_verdict;
    end
endmodule
